/* core/flic_top.sv */
// Four level interrupt controller with special function registers
`timescale 1ns/1ps
`default_nettype none
`include "flic_map.svh"
module flic_top #(
    parameter int NUM_SRC = 11
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_bit_wr_i,
    input wire logic [2:0] sfr_bit_sel_i,
    input wire logic sfr_bit_val_i,
    output logic [7:0] sfr_rdata_o,
    // Peripheral requests, index is polling position
    input wire logic [NUM_SRC-1:0] irq_req_i,
    // Core side
    input wire logic ack_i,
    input wire logic reti_i,
    output logic irq_o,
    output logic [15:0] vec_o,
    output logic [3:0] src_o,
    output logic [1:0] level_o,
    output logic [3:0] in_service_o
);
    logic [7:0] ien_main_reg;
    logic [7:0] ipl_main_reg;
    logic [7:0] iph_main_reg;
    logic [7:0] ien_second_reg;
    logic [7:0] ipl_second_reg;
    logic [7:0] iph_second_reg;
    logic [3:0] in_service_reg;
    logic [3:0] in_service_next;
    logic irq_reg;
    logic [15:0] vec_reg;
    logic [3:0] src_reg;
    logic [1:0] level_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    function automatic logic [7:0] reg_update(input logic [7:0] old,
        input logic [7:0] mask, input logic sel_hit, input logic bit_hit);
        logic [7:0] v;
        v = old;
        if (sel_hit && sfr_wr_i)
        begin
            v = sfr_wdata_i;
        end
        else if (bit_hit && sfr_bit_wr_i)
        begin
            v[sfr_bit_sel_i] = sfr_bit_val_i;
        end
        return v & mask;
    endfunction : reg_update

    function automatic logic [15:0] vec_of(input logic [3:0] idx);
        logic [15:0] v;
        v = `FLIC_VEC_BUSDEV;
        case (idx)
            flic_pkg::FLIC_SRC_EXT0: v = `FLIC_VEC_EXT0;
            flic_pkg::FLIC_SRC_TMR0: v = `FLIC_VEC_TMR0;
            flic_pkg::FLIC_SRC_EXT1: v = `FLIC_VEC_EXT1;
            flic_pkg::FLIC_SRC_TMR1: v = `FLIC_VEC_TMR1;
            flic_pkg::FLIC_SRC_CNT_ARRAY: v = `FLIC_VEC_CNT_ARRAY;
            flic_pkg::FLIC_SRC_SERIAL: v = `FLIC_VEC_SERIAL;
            flic_pkg::FLIC_SRC_TMR2: v = `FLIC_VEC_TMR2;
            flic_pkg::FLIC_SRC_KBD: v = `FLIC_VEC_KBD;
            flic_pkg::FLIC_SRC_TWI: v = `FLIC_VEC_TWI;
            flic_pkg::FLIC_SRC_SPI: v = `FLIC_VEC_SPI;
            default: v = `FLIC_VEC_BUSDEV;
        endcase
        return v;
    endfunction : vec_of

    // Address decode
    wire hit_ien_main = sfr_addr_i == `FLIC_ADDR_IEN_MAIN;
    wire hit_ipl_main = sfr_addr_i == `FLIC_ADDR_IPL_MAIN;
    wire hit_iph_main = sfr_addr_i == `FLIC_ADDR_IPH_MAIN;
    wire hit_ien_second = sfr_addr_i == `FLIC_ADDR_IEN_SECOND;
    wire hit_ipl_second = sfr_addr_i == `FLIC_ADDR_IPL_SECOND;
    wire hit_iph_second = sfr_addr_i == `FLIC_ADDR_IPH_SECOND;

    always_comb
    begin
        rdata_next = 8'h00;
        if (hit_ien_main)
            rdata_next = ien_main_reg;
        else if (hit_ipl_main)
            rdata_next = ipl_main_reg;
        else if (hit_iph_main)
            rdata_next = iph_main_reg;
        else if (hit_ien_second)
            rdata_next = ien_second_reg;
        else if (hit_ipl_second)
            rdata_next = ipl_second_reg;
        else if (hit_iph_second)
            rdata_next = iph_second_reg;
    end

    // Per-source enable and priority bits, in polling order
    wire [NUM_SRC-1:0] en_vec = NUM_SRC'({ien_second_reg[6],
        ien_second_reg[2], ien_second_reg[1], ien_second_reg[0],
        ien_main_reg[5], ien_main_reg[4], ien_main_reg[6],
        ien_main_reg[3:0]});
    wire [NUM_SRC-1:0] plo_vec = NUM_SRC'({ipl_second_reg[6],
        ipl_second_reg[2], ipl_second_reg[1], ipl_second_reg[0],
        ipl_main_reg[5], ipl_main_reg[4], ipl_main_reg[6],
        ipl_main_reg[3:0]});
    wire [NUM_SRC-1:0] phi_vec = NUM_SRC'({iph_second_reg[6],
        iph_second_reg[2], iph_second_reg[1], iph_second_reg[0],
        iph_main_reg[5], iph_main_reg[4], iph_main_reg[6],
        iph_main_reg[3:0]});
    wire global_en = ien_main_reg[`FLIC_BIT_GLOBAL_EN];

    // Highest level now in service
    wire cur_valid = |in_service_reg;
    wire [1:0] cur_lvl = in_service_reg[3] ? 2'h3 :
        in_service_reg[2] ? 2'h2 : in_service_reg[1] ? 2'h1 : 2'h0;

    wire [2*NUM_SRC-1:0] lvl_vec;
    wire [NUM_SRC-1:0] elig;
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : g_src
            assign lvl_vec[2*g +: 2] = {phi_vec[g], plo_vec[g]};
            // Enable, global gate, and strict preemption
            assign elig[g] = irq_req_i[g] && en_vec[g] && global_en
                && (!cur_valid || lvl_vec[2*g +: 2] > cur_lvl);
        end
    endgenerate

    wire win_valid;
    wire [3:0] win_idx;
    flic_pkg::flic_level_t win_lvl;
    flic_arbiter #(
        .NUM_SRC(NUM_SRC)
    ) u_arb (
        .elig_i(elig),
        .level_i(lvl_vec),
        .valid_o(win_valid),
        .idx_o(win_idx),
        .level_o(win_lvl)
    );

    // Return releases the top level, acknowledge marks the taken one
    wire [3:0] released = in_service_reg[3] ? {1'b0, in_service_reg[2:0]} :
        in_service_reg[2] ? {2'b00, in_service_reg[1:0]} :
        in_service_reg[1] ? {3'b000, in_service_reg[0]} : 4'h0;
    wire [3:0] after_ret = reti_i ? released : in_service_reg;
    wire take = ack_i && irq_reg;
    assign in_service_next = after_ret | (take ? 4'(1 << level_reg) : 4'h0);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ien_main_reg <= `FLIC_RST_REG;
            ipl_main_reg <= `FLIC_RST_REG;
            iph_main_reg <= `FLIC_RST_REG;
            ien_second_reg <= `FLIC_RST_REG;
            ipl_second_reg <= `FLIC_RST_REG;
            iph_second_reg <= `FLIC_RST_REG;
        end
        else
        begin
            ien_main_reg <= reg_update(ien_main_reg, `FLIC_MASK_IEN_MAIN,
                hit_ien_main, hit_ien_main);
            ipl_main_reg <= reg_update(ipl_main_reg, `FLIC_MASK_PRIO_MAIN,
                hit_ipl_main, hit_ipl_main);
            iph_main_reg <= reg_update(iph_main_reg, `FLIC_MASK_PRIO_MAIN,
                hit_iph_main, 1'b0);
            ien_second_reg <= reg_update(ien_second_reg, `FLIC_MASK_SECOND,
                hit_ien_second, 1'b0);
            ipl_second_reg <= reg_update(ipl_second_reg, `FLIC_MASK_SECOND,
                hit_ipl_second, 1'b0);
            iph_second_reg <= reg_update(iph_second_reg, `FLIC_MASK_SECOND,
                hit_iph_second, 1'b0);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_service_reg <= 4'h0;
            irq_reg <= 1'b0;
            vec_reg <= 16'h0000;
            src_reg <= 4'h0;
            level_reg <= 2'h0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            in_service_reg <= in_service_next;
            // Drop for one cycle after an acknowledge
            irq_reg <= win_valid && !ack_i;
            vec_reg <= vec_of(win_idx);
            src_reg <= win_idx;
            level_reg <= win_lvl;
            rdata_reg <= rdata_next;
        end
    end

    assign irq_o = irq_reg;
    assign vec_o = vec_reg;
    assign src_o = src_reg;
    assign level_o = level_reg;
    assign in_service_o = in_service_reg;
    assign sfr_rdata_o = rdata_reg;

    // Checker helpers: previous-cycle view of the candidates
    logic [NUM_SRC-1:0] en_q;
    logic [NUM_SRC-1:0] elig_q;
    logic [2*NUM_SRC-1:0] lvl_q;
    logic cur_valid_q;
    logic [1:0] cur_lvl_q;
    always_ff @(posedge clk_i)
    begin
        en_q <= en_vec;
        elig_q <= elig;
        lvl_q <= lvl_vec;
        cur_valid_q <= cur_valid;
        cur_lvl_q <= cur_lvl;
    end
    logic beaten;
    always_comb
    begin
        beaten = 1'b0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (elig_q[i] && (lvl_q[2*i +: 2] > level_reg
                || (lvl_q[2*i +: 2] == level_reg && 4'(i) < src_reg)))
                beaten = 1'b1;
        end
    end

    chk_global_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !global_en |=> !irq_o) else $error("request while globally disabled");
    chk_src_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> en_q[src_o]) else $error("disabled source forwarded");
    chk_top_block: assert property (@(posedge clk_i) disable iff (rst_i)
        in_service_reg[3] |=> !irq_o) else $error("request over level three");
    chk_preempt_higher: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o && cur_valid_q |-> level_o > cur_lvl_q)
        else $error("preemption by equal or lower level");
    chk_level_pick: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> level_o == lvl_q[2*src_o +: 2] && !beaten)
        else $error("wrong level chosen");
    chk_poll_order: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_o) |-> !beaten) else $error("polling order broken");
    chk_vec_cnt: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o && src_o == flic_pkg::FLIC_SRC_CNT_ARRAY |-> vec_o == 16'h0033)
        else $error("counter array vector wrong");
    chk_vec_spi: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o && src_o == flic_pkg::FLIC_SRC_SPI |-> vec_o == 16'h004b)
        else $error("serial peripheral vector wrong");
    chk_reset_zero: assert property (@(posedge clk_i)
        rst_i |=> ien_main_reg == 8'h00 && in_service_reg == 4'h0)
        else $error("enable register not zero after reset");
    chk_low_write: assert property (@(posedge clk_i) disable iff (rst_i)
        sfr_wr_i && hit_ipl_main |=> ipl_main_reg == {1'b0, $past(sfr_wdata_i[6:0])})
        else $error("low priority write lost");
    chk_high_write: assert property (@(posedge clk_i) disable iff (rst_i)
        sfr_wr_i && hit_iph_main ##1 hit_iph_main |=> sfr_rdata_o == iph_main_reg)
        else $error("high priority readback wrong");
    chk_second_write: assert property (@(posedge clk_i) disable iff (rst_i)
        sfr_wr_i && hit_ien_second |=> ien_second_reg == ($past(sfr_wdata_i) & 8'h47))
        else $error("second enable write wrong");
    chk_ack_mark: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_i && irq_o |=> in_service_reg[$past(level_o)] && !irq_o)
        else $error("acknowledged level not marked");
    chk_ret_release: assert property (@(posedge clk_i) disable iff (rst_i)
        reti_i && !ack_i && cur_valid |=> $countones(in_service_reg)
        == $countones($past(in_service_reg)) - 1) else $error("return not released");
endmodule : flic_top
`default_nettype wire

/* core/flic_map.svh */
// Register map, field positions, reset values and vectors of the controller
// What this block does
// - Eleven interrupt sources, each with a vector
// - Per-source enable bit gates every request
// - Global enable bit 7 blocks all sources
// - Level is high bit over low bit
// - Only a higher level preempts a running handler
// - Level three handler blocks every further request
// - Higher level wins among simultaneous requests
// - Fixed polling order breaks ties within a level
// - Counter array, keyboard, serial peripheral vectors fixed
// - Main enable register at A8h, resets zero
// - Main low priority register at B8h
// - Main high priority register at B7h
// - Second enable register at B1h
`ifndef FLIC_MAP_SVH
`define FLIC_MAP_SVH

`define FLIC_ADDR_IEN_MAIN 8'ha8
`define FLIC_ADDR_IPL_MAIN 8'hb8
`define FLIC_ADDR_IPH_MAIN 8'hb7
`define FLIC_ADDR_IEN_SECOND 8'hb1
`define FLIC_ADDR_IPL_SECOND 8'hb2
`define FLIC_ADDR_IPH_SECOND 8'hb3

`define FLIC_RST_REG 8'h00
`define FLIC_MASK_IEN_MAIN 8'hff
`define FLIC_MASK_PRIO_MAIN 8'h7f
`define FLIC_MASK_SECOND 8'h47
`define FLIC_BIT_GLOBAL_EN 7

`define FLIC_VEC_EXT0 16'h0003
`define FLIC_VEC_TMR0 16'h000b
`define FLIC_VEC_EXT1 16'h0013
`define FLIC_VEC_TMR1 16'h001b
`define FLIC_VEC_SERIAL 16'h0023
`define FLIC_VEC_TMR2 16'h002b
`define FLIC_VEC_CNT_ARRAY 16'h0033
`define FLIC_VEC_KBD 16'h003b
`define FLIC_VEC_TWI 16'h0043
`define FLIC_VEC_SPI 16'h004b
`define FLIC_VEC_BUSDEV 16'h0053

`endif

/* core/flic_pkg.sv */
// Types shared by the interrupt controller files
`default_nettype none
package flic_pkg;
    typedef logic [1:0] flic_level_t;
    // Source index equals polling position, zero polled first
    typedef enum logic [3:0] {
        FLIC_SRC_EXT0 = 4'h0,
        FLIC_SRC_TMR0 = 4'h1,
        FLIC_SRC_EXT1 = 4'h2,
        FLIC_SRC_TMR1 = 4'h3,
        FLIC_SRC_CNT_ARRAY = 4'h4,
        FLIC_SRC_SERIAL = 4'h5,
        FLIC_SRC_TMR2 = 4'h6,
        FLIC_SRC_KBD = 4'h7,
        FLIC_SRC_TWI = 4'h8,
        FLIC_SRC_SPI = 4'h9,
        FLIC_SRC_BUSDEV = 4'ha
    } flic_src_t;
endpackage : flic_pkg
`default_nettype wire

/* core/flic_arbiter.sv */
// Level then polling order arbiter
`timescale 1ns/1ps
`default_nettype none
module flic_arbiter #(
    parameter int NUM_SRC = 11
) (
    // Candidates
    input wire logic [NUM_SRC-1:0] elig_i,
    input wire logic [2*NUM_SRC-1:0] level_i,
    // Winner
    output logic valid_o,
    output logic [3:0] idx_o,
    output flic_pkg::flic_level_t level_o
);
    // Strictly greater keeps the lowest index among equals
    always_comb
    begin
        valid_o = 1'b0;
        idx_o = 4'h0;
        level_o = 2'h0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (elig_i[i] && (!valid_o || level_i[2*i +: 2] > level_o))
            begin
                valid_o = 1'b1;
                idx_o = 4'(i);
                level_o = level_i[2*i +: 2];
            end
        end
    end
endmodule : flic_arbiter
`default_nettype wire

/* tb/flic_core_model.sv */
// Behavioural processor core that takes and returns from interrupts
`timescale 1ns/1ps
`default_nettype none
module flic_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Controller side
    input wire logic irq_i,
    output logic ack_o,
    output logic reti_o,
    // Bench control
    input wire logic ack_en_i,
    input wire logic [3:0] ack_wait_i,
    input wire logic ret_req_i
);
    logic [3:0] wait_cnt_reg;
    logic ack_due;

    // Acknowledge only a request that has stood for the wait
    assign ack_due = irq_i && ack_en_i && !ack_o
        && (wait_cnt_reg >= ack_wait_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            reti_o <= 1'b0;
            wait_cnt_reg <= 4'h0;
        end
        else
        begin
            ack_o <= ack_due;
            reti_o <= ret_req_i;
            if (!irq_i || ack_o)
                wait_cnt_reg <= 4'h0;
            else if (wait_cnt_reg != 4'hf)
                wait_cnt_reg <= wait_cnt_reg + 4'h1;
        end
    end
endmodule : flic_core_model
`default_nettype wire

/* tb/four_level_interrupt_controller_test.sv */
// Self-checking bench for the four level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module four_level_interrupt_controller_test;
    logic clk_i;
    logic rst_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic sfr_bit_wr_i = 1'b0;
    logic [2:0] sfr_bit_sel_i = 3'h0;
    logic sfr_bit_val_i = 1'b0;
    logic [7:0] sfr_rdata_o;
    logic [10:0] irq_req_i = 11'h000;
    logic ack_i;
    logic reti_i;
    logic irq_o;
    logic [15:0] vec_o;
    logic [3:0] src_o;
    logic [1:0] level_o;
    logic [3:0] in_service_o;
    logic ack_en = 1'b1;
    logic [3:0] ack_wait = 4'h0;
    logic ret_req = 1'b0;
    int error_cnt = 0;
    int comparisons = 0;
    // Per polling position: vector, enable bits {second, main}
    logic [15:0] vec_tab [11] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
        16'h0033, 16'h0023, 16'h002b, 16'h003b, 16'h0043, 16'h004b, 16'h0053};
    logic [15:0] en_tab [11] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h0040, 16'h0010, 16'h0020, 16'h0100, 16'h0200, 16'h0400, 16'h4000};

    flic_top uut (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
        .sfr_bit_wr_i, .sfr_bit_sel_i, .sfr_bit_val_i, .sfr_rdata_o,
        .irq_req_i, .ack_i, .reti_i, .irq_o, .vec_o, .src_o, .level_o,
        .in_service_o);
    flic_core_model core (.clk_i, .rst_i, .irq_i(irq_o), .ack_o(ack_i),
        .reti_o(reti_i), .ack_en_i(ack_en), .ack_wait_i(ack_wait),
        .ret_req_i(ret_req));

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input string name, input logic [15:0] exp,
        input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        irq_req_i <= 11'h000;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge clk_i);
        sfr_wr_i <= 1'b0;
    endtask : wr

    task automatic bwr(input logic [7:0] a, input logic [2:0] b,
        input logic v);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_bit_sel_i <= b;
        sfr_bit_val_i <= v;
        sfr_bit_wr_i <= 1'b1;
        @(posedge clk_i);
        sfr_bit_wr_i <= 1'b0;
    endtask : bwr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
        input string name);
        @(posedge clk_i);
        sfr_addr_i <= a;
        @(posedge clk_i);
        #1;
        chk(name, {8'h00, exp}, {8'h00, sfr_rdata_o});
    endtask : rd

    task automatic req(input logic [10:0] v);
        @(posedge clk_i);
        irq_req_i <= v;
    endtask : req

    task automatic ret();
        @(posedge clk_i);
        ret_req <= 1'b1;
        @(posedge clk_i);
        ret_req <= 1'b0;
    endtask : ret

    task automatic wait_irq(input logic [15:0] vec, input logic [1:0] lvl,
        input logic [3:0] src);
        int n = 0;
        while (irq_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("irq", 16'h0001, {15'h0000, irq_o});
        chk("vector", vec, vec_o);
        chk("level", {14'h0000, lvl}, {14'h0000, level_o});
        chk("source", {12'h000, src}, {12'h000, src_o});
    endtask : wait_irq

    task automatic no_irq(input int cycles);
        repeat (cycles)
        begin
            @(posedge clk_i);
            #1;
            chk("idle irq", 16'h0000, {15'h0000, irq_o});
        end
    endtask : no_irq

    task automatic wait_svc(input logic [3:0] exp);
        int n = 0;
        while (in_service_o !== exp && n < 20)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("in service", {12'h000, exp}, {12'h000, in_service_o});
    endtask : wait_svc

    task automatic t_regs();
        logic [7:0] adr [7] = '{8'ha8, 8'hb8, 8'hb7, 8'hb1, 8'hb2, 8'hb3,
            8'ha2};
        logic [7:0] msk [7] = '{8'hff, 8'h7f, 8'h7f, 8'h47, 8'h47, 8'h47,
            8'h00};
        for (int i = 0; i < 7; i++)
        begin
            rd(adr[i], 8'h00, "reset value");
            wr(adr[i], 8'hff);
            rd(adr[i], msk[i], "masked value");
            wr(adr[i], 8'h00);
        end
        bwr(8'hb7, 3'd0, 1'b1);
        rd(8'hb7, 8'h00, "bit write ignored");
        bwr(8'hb8, 3'd6, 1'b1);
        rd(8'hb8, 8'h40, "bit write");
        bwr(8'hb8, 3'd6, 1'b0);
        rd(8'hb8, 8'h00, "bit clear");
    endtask : t_regs

    task automatic t_vectors();
        for (int i = 0; i < 11; i++)
        begin
            ack_wait <= (i == 10) ? 4'd5 : 4'd0;
            wr(8'ha8, 8'h80 | en_tab[i][7:0]);
            wr(8'hb1, en_tab[i][15:8]);
            req(11'h001 << i);
            wait_irq(vec_tab[i], 2'd0, i[3:0]);
            // Slow core: the request must stand until taken
            repeat ((i == 10) ? 4 : 0)
            begin
                @(posedge clk_i);
                #1;
                chk("irq held", 16'h0001, {15'h0000, irq_o});
            end
            wait_svc(4'h1);
            no_irq(2);
            req(11'h000);
            ret();
            wait_svc(4'h0);
        end
        ack_wait <= 4'h0;
    endtask : t_vectors

    task automatic t_gating();
        do_reset();
        ack_en <= 1'b0;
        wr(8'hb8, 8'h08);
        wr(8'hb7, 8'h08);
        wr(8'ha8, 8'h01);
        req(11'h7ff);
        no_irq(4);
        bwr(8'ha8, 3'd7, 1'b1);
        wait_irq(16'h0003, 2'd0, 4'h0);
        bwr(8'ha8, 3'd0, 1'b0);
        no_irq(3);
        // Second group: bus device block at level 3 beats keyboard
        wr(8'hb2, 8'h40);
        wr(8'hb3, 8'h40);
        wr(8'hb1, 8'h41);
        wait_irq(16'h0053, 2'd3, 4'ha);
        ack_en <= 1'b1;
    endtask : t_gating

    task automatic t_levels();
        do_reset();
        wr(8'ha8, 8'hff);
        wr(8'hb7, 8'h18);
        req(11'h009);
        wait_irq(16'h001b, 2'd2, 4'h3);
        wait_svc(4'h4);
        req(11'h021);
        no_irq(4);
        wr(8'hb7, 8'h1a);
        wr(8'hb8, 8'h02);
        req(11'h023);
        wait_irq(16'h000b, 2'd3, 4'h1);
        wait_svc(4'hc);
        wr(8'hb7, 8'h1e);
        wr(8'hb8, 8'h06);
        req(11'h025);
        no_irq(4);
        ret();
        wait_irq(16'h0013, 2'd3, 4'h2);
        wait_svc(4'hc);
    endtask : t_levels

    task automatic t_poll();
        do_reset();
        wr(8'ha8, 8'hff);
        wr(8'hb8, 8'h70);
        req(11'h070);
        wait_irq(16'h0033, 2'd1, 4'h4);
        wait_svc(4'h2);
        req(11'h060);
        ret();
        wait_irq(16'h0023, 2'd1, 4'h5);
        wait_svc(4'h2);
        req(11'h040);
        ret();
        wait_irq(16'h002b, 2'd1, 4'h6);
    endtask : t_poll

    task automatic final_report();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    initial
    begin
        do_reset();
        t_regs();
        t_vectors();
        t_gating();
        t_levels();
        t_poll();
        final_report();
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        final_report();
    end
endmodule : four_level_interrupt_controller_test
`default_nettype wire
